//--- logic/sacr_defs.vh
// Purpose: constants for the serial adapter control register bank
// Assumes: 8-bit I/O registers at consecutive byte offsets
// Notes: included by sacr_regs.v only
`ifndef SACR_DEFS_VH
`define SACR_DEFS_VH
// ========================================
// register offsets
`define SACR_OFS_ACCESS 3'h0
`define SACR_OFS_UNUSED 3'h1
`define SACR_OFS_LAYOUT 3'h2
`define SACR_OFS_RSTSTAT 3'h3
`define SACR_OFS_HOST_IRQ_GATE 3'h4
`define SACR_OFS_LINE 3'h5
`define SACR_OFS_SECLO 3'h6
`define SACR_OFS_SECHI 3'h7
// ========================================
// field positions
`define SACR_BIT_GATE 7
`define SACR_BIT_TARGET 6
`define SACR_BIT_LINEAR 7
`define SACR_BIT_IRQPEND 5
`define SACR_BIT_RSTDONE 4
`define SACR_BIT_IRQGATE 6
`define SACR_BIT_LLOOP 7
`define SACR_BIT_RLOOP 6
// ========================================
// fixed read constants of otherwise unused bits
`define SACR_RD_FIX_ACCESS 8'h10
`define SACR_RD_FIX_LAYOUT 8'h20
`define SACR_RD_FIX_RSTSTAT 8'h08
`define SACR_ZERO8 8'h00
// ========================================
// line mode codes
`define SACR_MODE_RS232 4'h2
`define SACR_MODE_RS485T 4'h4
`define SACR_MODE_RS485 4'h5
`define SACR_MODE_RS530 4'hd
`define SACR_MODE_RS530A 4'hf
`define SACR_MODE_V35 4'he
// ========================================
// reset values and timing
`define SACR_SEC_DEFAULT 16'hffff
`define SACR_CLK_HZ 20000000
`define SACR_RST_NS 320
`define SACR_PAGE_BITS 4
`endif

//--- logic/sacr_regs.v
// Purpose: host control and status register bank of a serial adapter
// Assumes: one 20 MHz clock; host strobes synchronous to sys_clk
// Notes: the controller core and memory itself live outside this block
//
// Operation
// R1: offset 0 bit 7 gates host access to RAM or controller; resets 0.
// R2: offset 0 bit 6 steers access: 1 RAM, 0 controller; resets 0.
// R3: offset 0 bits 3..0 pick one of sixteen 16K pages; read back.
// R4: unused read bits return fixed constants; don't-care write bits ignored.
// R5: offset 2 bit 7 selects linear 256K or paged window; resets 0.
// R6: offset 4 bit 6 is host interrupt enable, readable; resets 0.
// R7: offset 3 bit 5 reads controller interrupt, low while pending.
// R8: offset 3 bit 4 reads 0 while on-board reset active.
// R9: any single write to offset 3 starts a controller reset.
// R10: reset sequence lasts about 320 ns, status bit 0 meanwhile.
// R11: host waits for reset status 1 before touching the controller.
// R12: offset 5 bits 3..0 drive transceiver mode, read back, reset 0.
// R13: mode code 0010 selects RS-232.
// R14: termination on RXD, RXC, TXC in RS-530, 530A, 485T, V.35.
// R15: offsets 6 and 7 read the 16-bit security word, default FFFF.
// R16: one controller port pin selects transmit timing source.
// R17: address bits 6 and 7 drive controller data and DMA selects.
// R18: card claims one irq, 8 I/O bytes, 16K or 256K window.
// R19: 20 MHz clock feeds the controller and its ports 0 and 1.
// R20: external sync taken from carrier-detect line.
// R21: other mode codes: 0100, 0101, 1101, 1111, 1110.
// R22: offset 5 bits 7 and 6 drive local and remote loopback.
// R23: host irq asserted only when enabled and controller pending.
`timescale 1ns/1ns
`default_nettype none
`include "sacr_defs.vh"

module sacr_regs #(
  parameter [15:0] SECURITY_WORD = `SACR_SEC_DEFAULT,
  parameter PAGE_BITS = `SACR_PAGE_BITS
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [2:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  input wire [7:0] host_mem_addr,
  input wire host_sel,
  input wire controller_irq_pending_n,
  input wire rx_tx_clock,
  input wire ctrl_tx_clock,
  input wire timing_source_port,
  input wire carrier_detect_in,
  output wire host_access_gate,
  output wire window_target_select,
  output wire [PAGE_BITS-1:0] ram_page_select,
  output wire window_linear,
  output wire ram_sel,
  output wire ctrl_sel,
  output wire host_addr_bit6,
  output wire host_addr_bit7,
  output wire ctrl_reset_n,
  output wire reset_done_status,
  output wire host_irq_gate,
  output wire host_irq,
  output wire local_loop_out,
  output wire remote_loop_out,
  output wire [3:0] line_mode_select,
  output wire line_term_en,
  output wire mode_rs232,
  output wire tx_timing_out,
  output wire ctrl_port0_clk,
  output wire ctrl_port1_clk,
  output wire ctrl_clk,
  output wire ctrl_sync_in
);

// ========================================
// reset timing
localparam integer RST_CYC_RAW = (`SACR_RST_NS * (`SACR_CLK_HZ / 1000000))
  / 1000;
localparam integer RST_CYC = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;
localparam [3:0] RST_CYC_W = RST_CYC[3:0];

reg gate_reg;
reg target_reg;
reg [PAGE_BITS-1:0] page_reg;
reg linear_reg;
reg host_irq_gate_reg;
reg lloop_reg;
reg rloop_reg;
reg [3:0] mode_reg;
reg [3:0] rst_cnt_reg;
reg [3:0] rst_cnt_next;
reg irq_s1_reg;
reg irq_s2_reg;
reg sync_s1_reg;
reg sync_s2_reg;
reg tsel_s1_reg;
reg tsel_s2_reg;

// decode of a register write at a given offset
// R18: 8-byte I/O decode, one irq
function wr_hit;
  input [2:0] addr;
  input wr;
  input [2:0] ofs;
  begin
    wr_hit = wr & (addr == ofs);
  end
endfunction

// ========================================
// control register writes
always @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    gate_reg <= 1'b0;
    target_reg <= 1'b0;
    page_reg <= {PAGE_BITS{1'b0}};
    linear_reg <= 1'b0;
    host_irq_gate_reg <= 1'b0;
    lloop_reg <= 1'b0;
    rloop_reg <= 1'b0;
    mode_reg <= 4'h0;
  end
  else
  begin
    if (wr_hit(io_addr, io_wr, `SACR_OFS_ACCESS))
    begin
      // R1: access gate write
      gate_reg <= io_wdata[`SACR_BIT_GATE];
      // R2: target steer write
      target_reg <= io_wdata[`SACR_BIT_TARGET];
      // R3: page select write
      page_reg <= io_wdata[PAGE_BITS-1:0];
    end
    // R5: window layout write
    if (wr_hit(io_addr, io_wr, `SACR_OFS_LAYOUT))
      linear_reg <= io_wdata[`SACR_BIT_LINEAR];
    // R6: interrupt enable write
    if (wr_hit(io_addr, io_wr, `SACR_OFS_HOST_IRQ_GATE))
      host_irq_gate_reg <= io_wdata[`SACR_BIT_IRQGATE];
    if (wr_hit(io_addr, io_wr, `SACR_OFS_LINE))
    begin
      // R22: loopback controls
      lloop_reg <= io_wdata[`SACR_BIT_LLOOP];
      rloop_reg <= io_wdata[`SACR_BIT_RLOOP];
      // R12: line mode latch
      mode_reg <= io_wdata[3:0];
    end
  end
end

// ========================================
// controller reset sequencer
always @*
begin
  rst_cnt_next = rst_cnt_reg;
  // R9: any write to offset 3 restarts the sequence
  if (wr_hit(io_addr, io_wr, `SACR_OFS_RSTSTAT))
    rst_cnt_next = RST_CYC_W;
  else if (rst_cnt_reg != 4'h0)
    rst_cnt_next = rst_cnt_reg - 4'h1;
end

always @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
    rst_cnt_reg <= 4'h0;
  else
    rst_cnt_reg <= rst_cnt_next;
end

// R10: status low for the counted 6 cycles, 300 ns at 20 MHz
assign ctrl_reset_n = (rst_cnt_reg == 4'h0);
// R8: reset status read bit
assign reset_done_status = ctrl_reset_n;

// ========================================
// synchronisers for pins from the controller and connector
// the transmit clocks themselves are passed through as clocks, not sampled; only their select is
always @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    irq_s1_reg <= 1'b1;
    irq_s2_reg <= 1'b1;
    sync_s1_reg <= 1'b0;
    sync_s2_reg <= 1'b0;
    tsel_s1_reg <= 1'b0;
    tsel_s2_reg <= 1'b0;
  end
  else
  begin
    irq_s1_reg <= controller_irq_pending_n;
    irq_s2_reg <= irq_s1_reg;
    sync_s1_reg <= carrier_detect_in;
    sync_s2_reg <= sync_s1_reg;
    tsel_s1_reg <= timing_source_port;
    tsel_s2_reg <= tsel_s1_reg;
  end
end

// ========================================
// outputs
assign host_access_gate = gate_reg;
assign window_target_select = target_reg;
assign ram_page_select = page_reg;
assign window_linear = linear_reg;
// R1: access blocked while gate low
// R2: steer to RAM or controller
assign ram_sel = host_sel & gate_reg & target_reg;
assign ctrl_sel = host_sel & gate_reg & ~target_reg;
// R17: address bits to controller selects
assign host_addr_bit6 = host_mem_addr[6];
assign host_addr_bit7 = host_mem_addr[7];
assign host_irq_gate = host_irq_gate_reg;
// R23: gated interrupt
assign host_irq = host_irq_gate_reg & ~irq_s2_reg;
assign local_loop_out = lloop_reg;
assign remote_loop_out = rloop_reg;
assign line_mode_select = mode_reg;
// R13: RS-232 decode
assign mode_rs232 = (mode_reg == `SACR_MODE_RS232);
// R14: termination modes
// R21: terminated 485 listed, unterminated 485 excluded
assign line_term_en = (mode_reg == `SACR_MODE_RS530) |
  (mode_reg == `SACR_MODE_RS530A) |
  (mode_reg == `SACR_MODE_RS485T) |
  (mode_reg == `SACR_MODE_V35);
// R16: transmit timing mux, glitches possible on a live select change
assign tx_timing_out = tsel_s2_reg ? rx_tx_clock : ctrl_tx_clock;
// R19: board clock to controller and ports 0 and 1
assign ctrl_clk = sys_clk;
assign ctrl_port0_clk = sys_clk;
assign ctrl_port1_clk = sys_clk;
// R20: external sync from carrier detect
assign ctrl_sync_in = sync_s2_reg;

// ========================================
// register read path, registered one cycle after io_rd
always @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
    io_rdata <= `SACR_ZERO8;
  else if (io_rd)
  begin
    case (io_addr)
      // R3: page readback; R4: fixed bit 4 set
      `SACR_OFS_ACCESS:
        io_rdata <= `SACR_RD_FIX_ACCESS | {4'h0, page_reg};
      // R4: unused register reads zero
      `SACR_OFS_UNUSED:
        io_rdata <= `SACR_ZERO8;
      `SACR_OFS_LAYOUT:
        io_rdata <= `SACR_RD_FIX_LAYOUT | {linear_reg, 7'h00};
      // R7: pending low; R8: reset status
      `SACR_OFS_RSTSTAT:
        io_rdata <= `SACR_RD_FIX_RSTSTAT |
          {2'b00, irq_s2_reg, reset_done_status, 4'h0};
      `SACR_OFS_HOST_IRQ_GATE:
        io_rdata <= {1'b0, host_irq_gate_reg, 6'h00};
      `SACR_OFS_LINE:
        io_rdata <= {lloop_reg, rloop_reg, 2'b00, mode_reg};
      // R15: security word bytes
      `SACR_OFS_SECLO:
        io_rdata <= SECURITY_WORD[7:0];
      `SACR_OFS_SECHI:
        io_rdata <= SECURITY_WORD[15:8];
      default:
        io_rdata <= `SACR_ZERO8;
    endcase
  end
end

endmodule // sacr_regs
`default_nettype wire

//--- dv/sacr_regs_assertions.sv
// Purpose: port checks of the register bank
// Assumes: one clock, async low reset
// Notes: board reset pulse is six cycles
`timescale 1ns/1ns
`default_nettype none
module sacr_regs_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [2:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic host_sel,
  input wire logic host_access_gate,
  input wire logic window_target_select,
  input wire logic ram_sel,
  input wire logic ctrl_sel,
  input wire logic reset_done_status,
  input wire logic host_irq_gate,
  input wire logic host_irq,
  input wire logic controller_irq_pending_n,
  input wire logic [3:0] line_mode_select,
  input wire logic line_term_en,
  input wire logic mode_rs232
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ========================================
  // board reset: six low cycles, then done
  sequence rst_low;
    !reset_done_status [*6];
  endsequence
  sequence rst_seq;
    rst_low ##1 reset_done_status;
  endsequence
  rst_len_a: assert property (io_wr && io_addr == 3'h3 |=> rst_seq)
    else $error("reset pulse length wrong");
  gate_block_a: assert property (!host_access_gate |-> !ram_sel && !ctrl_sel)
    else $error("access not blocked");
  steer_a: assert property (ram_sel == (host_sel && host_access_gate && window_target_select))
    else $error("ram select wrong");
  irq_gate_a: assert property (host_irq == (host_irq_gate && !$past(controller_irq_pending_n, 2)))
    else $error("host irq wrong");
  mode_read_a: assert property (io_rd && io_addr == 3'h5 |=> io_rdata[3:0] == $past(line_mode_select))
    else $error("mode readback wrong");
  zero_read_a: assert property (io_rd && io_addr == 3'h1 |=> io_rdata == 8'h00)
    else $error("offset 1 not zero");
  term_sel_a: assert property (line_term_en == (line_mode_select inside {4'h4, 4'hd, 4'he, 4'hf}))
    else $error("termination wrong");
  rs232_sel_a: assert property (mode_rs232 == (line_mode_select == 4'h2))
    else $error("rs232 select wrong");
endmodule // sacr_regs_checker
`default_nettype wire

//--- dv/sacr_ctrl_model.sv
// Purpose: serial controller stand-in
// Assumes: bench clock
// Notes: irq raised on command, dropped by board reset
`timescale 1ns/1ns
`default_nettype none
module sacr_ctrl_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ctrl_reset_n,
  input wire logic raise_irq,
  output logic irq_pending_n,
  output wire logic own_tx_clock,
  output wire logic rx_tx_clock
);
  logic [1:0] div_reg;
  // ========================================
  // low-active pending
  always @(posedge sys_clk or negedge ctrl_reset_n or negedge rst_n)
    if (!ctrl_reset_n || !rst_n)
      irq_pending_n <= 1'b1;
    else if (raise_irq)
      irq_pending_n <= 1'b0;
  // two tx clocks of different rate so the mux choice shows
  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      div_reg <= 2'h0;
    else
      div_reg <= div_reg + 2'h1;
  assign own_tx_clock = div_reg[0];
  assign rx_tx_clock = div_reg[1];
endmodule // sacr_ctrl_model
`default_nettype wire

//--- dv/serial_adapter_control_regs_test.sv
// Purpose: self-checking bench of the register bank
// Assumes: strobes set on the rising edge
// Notes: security word value is arbitrary
`timescale 1ns/1ns
`default_nettype none
module serial_adapter_control_regs_test;
  localparam logic [15:0] SEC = 16'h5aa5; // arbitrary value
  logic sys_clk = 0, rst_n = 0, io_wr = 0, io_rd = 0, host_sel = 0;
  logic [2:0] io_addr = 0;
  logic [7:0] io_wdata = 0, host_mem_addr = 8'h40, e;
  logic timing_source_port = 0, carrier_detect_in = 0, raise = 0;
  wire [7:0] io_rdata;
  wire ram_sel, ctrl_sel, host_addr_bit6, reset_done_status, host_irq;
  wire ctrl_reset_n, tx_timing_out, ctrl_sync_in, line_term_en, mode_rs232;
  wire own_clk, rx_tx_clock, pend_n;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  logic [18:0] rows [0:7] = '{{3'h0, 8'hc5, 8'h15}, {3'h1, 8'hff, 8'h00},
    {3'h2, 8'hff, 8'ha0}, {3'h4, 8'hff, 8'h40}, {3'h5, 8'hc2, 8'hc2},
    {3'h5, 8'h3d, 8'h0d}, {3'h6, 8'h00, SEC[7:0]}, {3'h7, 8'h00, SEC[15:8]}};
  logic [3:0] modes [0:5] = '{4'h2, 4'h4, 4'h5, 4'hd, 4'hf, 4'he};
  sacr_regs #(.SECURITY_WORD(SEC)) sacr_regs_inst (.sys_clk, .rst_n,
    .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .host_mem_addr,
    .host_sel, .controller_irq_pending_n(pend_n), .rx_tx_clock,
    .ctrl_tx_clock(own_clk), .timing_source_port, .carrier_detect_in,
    .host_access_gate(), .window_target_select(), .ram_page_select(),
    .window_linear(), .ram_sel, .ctrl_sel, .host_addr_bit6,
    .host_addr_bit7(), .ctrl_reset_n, .reset_done_status,
    .host_irq_gate(), .host_irq, .local_loop_out(), .remote_loop_out(),
    .line_mode_select(), .line_term_en, .mode_rs232, .tx_timing_out,
    .ctrl_port0_clk(), .ctrl_port1_clk(), .ctrl_clk(), .ctrl_sync_in);
  sacr_ctrl_model sacr_ctrl_model_inst (.sys_clk, .rst_n, .ctrl_reset_n,
    .raise_irq(raise), .irq_pending_n(pend_n), .own_tx_clock(own_clk),
    .rx_tx_clock);
  // ========================================
  // clock and hang guard
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge sys_clk);
    io_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] x);
    @(posedge sys_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge sys_clk);
    io_rd <= 1'b0;
    @(negedge sys_clk);
    chk("read", io_rdata, x);
  endtask
  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ========================================
  // reset reads and table first, then mode, select, reset, irq and timing cases
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(3'h0, 8'h10);
    rd(3'h3, 8'h38);
    foreach (rows[i])
    begin
      wr(rows[i][18:16], rows[i][15:8]);
      rd(rows[i][18:16], rows[i][7:0]);
    end
    foreach (modes[i])
    begin
      wr(3'h5, {4'h0, modes[i]});
      @(negedge sys_clk);
      e = {7'h0, modes[i] == 4'h4 || modes[i] > 4'hc};
      chk("term", {7'h0, line_term_en}, e);
      chk("rs232", {7'h0, mode_rs232}, {7'h0, modes[i] == 4'h2});
    end
    @(posedge sys_clk);
    host_sel <= 1'b1;
    wr(3'h0, 8'hc0);
    @(negedge sys_clk);
    chk("select", {5'h0, ram_sel, ctrl_sel, host_addr_bit6}, 8'h05);
    wr(3'h3, 8'h00);
    repeat (6)
    begin
      @(negedge sys_clk);
      chk("rst low", {7'h0, reset_done_status}, 8'h00);
    end
    @(negedge sys_clk);
    chk("rst end", {7'h0, reset_done_status}, 8'h01);
    wr(3'h3, 8'h5a);
    rd(3'h3, 8'h28);
    repeat (8) @(posedge sys_clk);
    wr(3'h4, 8'h40);
    raise <= 1'b1;
    @(posedge sys_clk);
    raise <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("irq", {7'h0, host_irq}, 8'h01);
    rd(3'h3, 8'h18);
    wr(3'h4, 8'h00);
    @(negedge sys_clk);
    chk("irq off", {7'h0, host_irq}, 8'h00);
    for (int i = 1; i >= 0; i--)
    begin
      @(posedge sys_clk);
      timing_source_port <= i[0];
      carrier_detect_in <= i[0];
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      e = {7'h0, i[0] ? rx_tx_clock : own_clk};
      chk("tx_timing_out", {7'h0, tx_timing_out}, e);
      chk("sync", {7'h0, ctrl_sync_in}, {7'h0, i[0]});
    end
    complete_run();
  end
endmodule // serial_adapter_control_regs_test
bind sacr_regs sacr_regs_checker sacr_regs_checker_inst (.sys_clk, .rst_n,
  .io_addr, .io_wr, .io_rd, .io_rdata, .host_sel, .host_access_gate,
  .window_target_select, .ram_sel, .ctrl_sel, .reset_done_status,
  .host_irq_gate, .host_irq, .controller_irq_pending_n, .line_mode_select,
  .line_term_en, .mode_rs232);
`default_nettype wire
